/* rtl/e1_framer_dev.sv */
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module e1_framer_dev #(
   parameter logic [1:0] FRAMER_ID = 2'h0    // index of this framer
) (
   input  wire logic mclk_i,                 // 20 MHz system clock
   input  wire logic nrst_i,                 // async reset, active low
   e1_link_if.dev    lnk,                    // pin side of the framer
   output      logic bpv_o,                  // bipolar violation pulse
   output      logic rx_mf_o                 // receive multiframe pulse
);
   import e1_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] s1, s2, s3, stab;
      logic [7:0]       tbit;
      logic [3:0]       tfrm;
      logic             tin, thold, tss_pend, tmark, tpos, tneg, tsync;
      logic [7:0]       rbit;
      logic [3:0]       rfrm;
      logic             rdat, rlast, rhold, rser, rsync, rx_multiframe_sync;
      logic [7:0]       sbit;
      logic [3:0]       sfrm;
      logic             bipolar_violation, rmf;
      logic [7:0]       tcr, ccr, sr, imr, alat, rdata;
   } dev_state_type;

   localparam dev_state_type RST_STATE = '{
      s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, stab: PIN_RST, default: '0};

   dev_state_type    r, n;
   logic [PIN_W-1:0] pins, agree, rise, fall, lev;
   logic             tx_es, rx_es, rsync_in, tsync_out, mf_sel, nrz;
   logic             tbound, rbound, rmfb, sbound, bpv_ev, p, q;
   logic             sel, bts, mux, rd_act, wr_commit, test;
   logic [7:0]       addr, wdata, ev;

   // framer select decode and chip select
   function automatic logic framer_hit(input logic [1:0] fs,
                                       input logic       cs_n);
      framer_hit = !cs_n && (fs == FRAMER_ID);
   endfunction

   assign pins = {lnk.d, lnk.a, lnk.fs, lnk.bts, lnk.mux, lnk.test,
                  lnk.cs_n, lnk.wr_n, lnk.rd_n, lnk.ale_a6, lnk.rsync,
                  lnk.rx_system_clock, lnk.rneg, lnk.rpos, lnk.rclk, lnk.tx_system_sync,
                  lnk.tsync, lnk.tx_system_clock, lnk.tser, lnk.tclk};

   // next state of the whole framer end
   always_comb begin
      n = r;
      // every pin passes three flops; a change counts once s2 and s3 agree
      n.s1  = pins;
      n.s2  = r.s1;
      n.s3  = r.s2;
      agree = ~(r.s2 ^ r.s3);
      rise  = agree & r.s3 & ~r.stab;
      fall  = agree & ~r.s3 & r.stab;
      n.stab = (agree & r.s3) | (~agree & r.stab);
      lev   = r.stab;

      tx_es     = r.ccr[CCR_TX_ES];
      rx_es     = r.ccr[CCR_RX_ES];
      rsync_in  = rx_es & r.ccr[CCR_RSYNC_IN];
      tsync_out = r.ccr[CCR_TSYNC_OUT];
      mf_sel    = r.ccr[CCR_MF];
      nrz       = r.tcr[TCR_NRZ];
      test      = lev[P_TEST];
      ev        = 8'h00;
      tbound    = 1'b0;
      rbound    = 1'b0;
      rmfb      = 1'b0;
      sbound    = 1'b0;
      bpv_ev    = 1'b0;
      p         = lev[P_RPOS];
      q         = lev[P_RNEG];
      n.bipolar_violation     = 1'b0;
      n.rmf     = 1'b0;

      // transmit input: line clock, or system clock into a one-bit hold
      if (tx_es && fall[P_TSYS]) begin
         n.thold = lev[P_TSER];
      end
      if (fall[P_TCLK]) begin
         n.tin = tx_es ? r.thold : lev[P_TSER];
      end

      // formatter step on each rising transmit line clock
      if (rise[P_TCLK]) begin
         tbound  = (r.tbit == 8'h00) && (!mf_sel || r.tfrm == 4'h0);
         n.tsync = tsync_out & tbound;
         if ((!tsync_out && lev[P_TSYNC]) || r.tss_pend) begin
            n.tbit     = 8'h01;
            n.tss_pend = 1'b0;
            if (mf_sel) begin
               n.tfrm = 4'h0;
            end
         end else begin
            n.tbit = r.tbit + 8'h01;
            if (r.tbit == FRAME_LAST) begin
               n.tfrm = r.tfrm + 4'h1;
            end
         end
         if (r.tbit == 8'h00 && r.tfrm == 4'h0) begin
            ev[SR_TMF] = 1'b1;
         end
         // alternate mark polarity unless NRZ is selected
         if (nrz) begin
            n.tpos = r.tin;
            n.tneg = 1'b0;
         end else begin
            n.tpos = r.tin & ~r.tmark;
            n.tneg = r.tin & r.tmark;
            n.tmark = r.tmark ^ r.tin;
         end
      end

      // system sync is remembered and applied at the next line edge
      if (tx_es && rise[P_TSYS] && lev[P_TX_SYSTEM_SYNC]) begin
         n.tss_pend = 1'b1;
      end

      // receive rails on falling line clock; tied rails never differ
      if (fall[P_RCLK]) begin
         n.rdat = p | q;
         if (p ^ q) begin
            bpv_ev  = (p == r.rlast);
            n.rlast = p;
         end
      end
      if (bpv_ev) begin
         ev[SR_BPV] = 1'b1;
         n.bipolar_violation      = 1'b1;
      end

      // receive framer step on each rising receive line clock
      if (rise[P_RCLK]) begin
         rbound = (r.rbit == 8'h00);
         rmfb   = rbound && (r.rfrm == 4'h0);
         n.rbit = r.rbit + 8'h01;
         if (r.rbit == FRAME_LAST) begin
            n.rfrm = r.rfrm + 4'h1;
         end
         n.rhold = r.rdat;
         if (!rx_es) begin
            n.rser   = r.rdat;
            n.rx_multiframe_sync = rmfb;
         end
         if (!rsync_in) begin
            n.rsync = mf_sel ? rmfb : rbound;
         end
         ev[SR_RFRM] = rbound;
         ev[SR_RMF]  = rmfb;
         n.rmf       = rmfb;
      end

      // system side of the receive store
      if (rx_es && rise[P_RSYS]) begin
         sbound   = (r.sbit == 8'h00) && (r.sfrm == 4'h0);
         n.rser   = r.rhold;
         n.rx_multiframe_sync = sbound;
         if (rsync_in && lev[P_RSYNC]) begin
            n.sbit = 8'h01;
            if (mf_sel) begin
               n.sfrm = 4'h0;
            end
         end else begin
            n.sbit = r.sbit + 8'h01;
            if (r.sbit == FRAME_LAST) begin
               n.sfrm = r.sfrm + 4'h1;
            end
         end
      end

      // parallel port decode
      bts = lev[P_BTS];
      mux = lev[P_MUX];
      sel = framer_hit(lev[P_FS+:2], lev[P_CS]);
      // data strobe style: strobe high, direction high reads
      rd_act = sel && (bts ? (lev[P_RD] && lev[P_WR])
                           : !lev[P_RD]);
      wr_commit = sel && (bts ? (fall[P_RD] && !lev[P_WR])
                              : rise[P_WR]);
      if (mux && rise[P_ALE]) begin
         n.alat = lev[P_D+:8];
      end
      addr  = mux ? r.alat
                  : {lev[P_A+6], lev[P_ALE], lev[P_A+:6]};
      wdata = lev[P_D+:8];

      // read data is registered every cycle from the decoded address
      case (addr)
         REG_SR1:  n.rdata = r.sr;
         REG_TCR1: n.rdata = r.tcr;
         REG_CCR1: n.rdata = r.ccr;
         REG_IMR1: n.rdata = r.imr;
         default:  n.rdata = 8'h00;
      endcase
      if (wr_commit) begin
         case (addr)
            REG_SR1:  n.sr  = r.sr & ~wdata;
            REG_TCR1: n.tcr = wdata;
            REG_CCR1: n.ccr = wdata;
            REG_IMR1: n.imr = wdata;
            default:  ;
         endcase
      end
      // events set after the clear so a simultaneous event is kept
      n.sr = n.sr | ev;
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= RST_STATE;
      end else begin
         r <= n;
      end
   end

   // pin drivers; the test input floats every output
   assign lnk.tpos         = r.tpos;
   assign lnk.tneg         = r.tneg;
   assign lnk.rser         = r.rser;
   assign lnk.rx_multiframe_sync       = r.rx_multiframe_sync;
   assign lnk.out_oe       = !test;
   assign lnk.dev_tsync_o  = r.tsync;
   assign lnk.dev_tsync_oe = !test && tsync_out;
   assign lnk.dev_rsync_o  = r.rsync;
   assign lnk.dev_rsync_oe = !test && !rsync_in;
   assign lnk.dev_d_o      = r.rdata;
   assign lnk.dev_d_oe     = !test && rd_act;
   // open drain: only ever pulls low
   assign lnk.int_oe       = !test && |(r.sr & r.imr);
   assign bpv_o            = r.bipolar_violation;
   assign rx_mf_o          = r.rmf;
endmodule

/* common/e1_pkg.sv */
package e1_pkg;
   // clock rates and link timing
   localparam int MCLK_HZ       = 20_000_000;
   localparam int MCLK_NS       = 50;
   localparam int LINE_HZ       = 2_048_000;
   localparam int TCLK_HALF_NS  = 200;
   localparam int TCLK_HALF_CYC = (TCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int BUS_PH_CYC    = 10;
   // frame geometry: 256 bits per frame, 16 frames per multiframe
   localparam logic [7:0] FRAME_LAST = 8'hFF;
   // positions in the synchronised pin vector of the framer end
   localparam int P_TCLK = 0, P_TSER = 1, P_TSYS = 2, P_TSYNC = 3;
   localparam int P_TX_SYSTEM_SYNC = 4, P_RCLK = 5, P_RPOS = 6, P_RNEG = 7;
   localparam int P_RSYS = 8, P_RSYNC = 9, P_ALE = 10, P_RD = 11;
   localparam int P_WR = 12, P_CS = 13, P_TEST = 14, P_MUX = 15;
   localparam int P_BTS = 16, P_FS = 17, P_A = 19, P_D = 26, PIN_W = 34;
   // strobes and select idle high after reset
   localparam logic [PIN_W-1:0] PIN_RST = 34'h0_0000_3800;
   // register offsets on the parallel port
   localparam logic [7:0] REG_SR1  = 8'h06;
   localparam logic [7:0] REG_TCR1 = 8'h12;
   localparam logic [7:0] REG_CCR1 = 8'h14;
   localparam logic [7:0] REG_IMR1 = 8'h16;
   localparam logic [7:0] REG_RST  = 8'h00;
   // field positions
   localparam int TCR_NRZ = 7;
   localparam int CCR_TX_ES = 0, CCR_RX_ES = 1, CCR_RSYNC_IN = 2;
   localparam int CCR_TSYNC_OUT = 3, CCR_MF = 4;
   localparam int SR_BPV = 0, SR_RFRM = 1, SR_RMF = 2, SR_TMF = 3;
endpackage

/* common/e1_link_if.sv */
interface e1_link_if;
   logic       tclk, tser, tx_system_clock, tx_system_sync, tpos, tneg;
   logic       rclk, rpos, rneg, rser, rx_multiframe_sync, rx_system_clock;
   logic       dev_tsync_o, dev_tsync_oe, host_tsync_o, host_tsync_oe;
   logic       tsync;
   logic       dev_rsync_o, dev_rsync_oe, rsync;
   logic       int_oe, int_n, out_oe;
   logic       mux, bts, ale_a6, rd_n, wr_n, cs_n, test;
   logic [1:0] fs;
   logic [6:0] a;
   logic [7:0] dev_d_o, host_d_o, d;
   logic       dev_d_oe, host_d_oe;

   // wire levels from the enables; undriven syncs rest low, the data bus rests high, int_n pulled up
   assign tsync = dev_tsync_oe ? dev_tsync_o
                : (host_tsync_oe ? host_tsync_o : 1'b0);
   assign rsync = dev_rsync_oe ? dev_rsync_o : 1'b0;
   assign int_n = int_oe ? 1'b0 : 1'b1;
   assign d     = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hFF);

   modport dev (
      input  tclk, tser, tx_system_clock, tx_system_sync, tsync, rclk, rpos, rneg,
             rx_system_clock, rsync, mux, bts, ale_a6, rd_n, wr_n, cs_n, test, fs,
             a, d,
      output tpos, tneg, rser, rx_multiframe_sync, dev_tsync_o, dev_tsync_oe,
             dev_rsync_o, dev_rsync_oe, int_oe, out_oe, dev_d_o, dev_d_oe
   );
   modport host (
      input  tpos, tneg, rser, rx_multiframe_sync, tsync, rsync, int_n, out_oe, d,
      output tclk, tser, tx_system_clock, tx_system_sync, rclk, rpos, rneg, rx_system_clock,
             host_tsync_o, host_tsync_oe, mux, bts, ale_a6, rd_n, wr_n,
             cs_n, test, fs, a, host_d_o, host_d_oe
   );
endinterface

/* rtl/e1_host_end.sv */
module e1_host_end #(
   parameter logic MUX_MODE = 1'b0,          // strap for bus mode pin
   parameter logic BTS_MODE = 1'b0           // strap for bus type pin
) (
   input  wire logic       mclk_i,           // 20 MHz system clock
   input  wire logic       nrst_i,           // async reset, active low
   e1_link_if.host         lnk,              // pin side toward framer
   input  wire logic [7:0] addr_i,           // register address
   input  wire logic [1:0] fs_i,             // framer index
   input  wire logic [7:0] wdata_i,          // write data
   input  wire logic       wr_i,             // write strobe
   input  wire logic       rd_i,             // read strobe
   output      logic [7:0] rdata_o,          // read data
   output      logic       busy_o,           // bus cycle running
   output      logic       done_o,           // bus cycle finished pulse
   input  wire logic       tx_bit_i,         // next transmit bit
   input  wire logic       rx_line_i,        // next receive line bit
   input  wire logic       test_i,           // float framer outputs
   output      logic       irq_o             // interrupt line active
);
   import e1_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE   = 4'b0001,
      H_SETUP  = 4'b0010,
      H_STROBE = 4'b0100,
      H_HOLD   = 4'b1000
   } host_st_type;

   typedef struct packed {
      host_st_type st;
      logic [3:0]  ph;
      logic [2:0]  div;
      logic        clk, tser, rline, isrd, done, csn, rdn, wrn, doe;
      logic [7:0]  addr, wdata, rdata;
      logic [1:0]  fs;
      logic [8:0]  s1, s2, s3, stab;
   } host_state_type;

   localparam host_state_type RST_STATE = '{
      st: H_IDLE, csn: 1'b1, rdn: 1'b1, wrn: 1'b1, s1: 9'h100,
      s2: 9'h100, s3: 9'h100, stab: 9'h100, default: '0};

   host_state_type r, n;
   logic [8:0]     agree;

   // next state of the host end
   always_comb begin
      n = r;
      // data bus and interrupt line pass three flops
      n.s1   = {lnk.int_n, lnk.d};
      n.s2   = r.s1;
      n.s3   = r.s2;
      agree  = ~(r.s2 ^ r.s3);
      n.stab = (agree & r.s3) | (~agree & r.stab);
      n.done = 1'b0;

      // line clock from a divider; bits change as the clock rises so
      // the framer sees them settled at the falling edge
      if (r.div == 3'(TCLK_HALF_CYC - 1)) begin
         n.div = 3'h0;
         n.clk = !r.clk;
         if (!r.clk) begin
            n.tser  = tx_bit_i;
            n.rline = rx_line_i;
         end
      end else begin
         n.div = r.div + 3'h1;
      end

      // one bus cycle at a time; the framer samples through flops so
      // every phase lasts several clocks
      unique case (r.st)
         H_IDLE: begin
            if (wr_i || rd_i) begin
               n.st    = H_SETUP;
               n.ph    = 4'h0;
               n.addr  = addr_i;
               n.fs    = fs_i;
               n.wdata = wdata_i;
               n.isrd  = rd_i;
               n.csn   = 1'b0;
               n.doe   = !rd_i;
            end
         end
         H_SETUP: begin
            n.ph = r.ph + 4'h1;
            if (r.ph == 4'(BUS_PH_CYC - 1)) begin
               n.st  = H_STROBE;
               n.ph  = 4'h0;
               n.rdn = !r.isrd;
               n.wrn = r.isrd;
            end
         end
         H_STROBE: begin
            n.ph = r.ph + 4'h1;
            if (r.ph == 4'(BUS_PH_CYC - 1)) begin
               n.st  = H_HOLD;
               n.ph  = 4'h0;
               n.rdn = 1'b1;
               n.wrn = 1'b1;
               if (r.isrd) begin
                  n.rdata = r.stab[7:0];
               end
            end
         end
         H_HOLD: begin
            n.ph = r.ph + 4'h1;
            if (r.ph == 4'(BUS_PH_CYC - 1)) begin
               n.st   = H_IDLE;
               n.csn  = 1'b1;
               n.doe  = 1'b0;
               n.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= RST_STATE;
      end else begin
         r <= n;
      end
   end

   // pins toward the framer; unused system clocks and syncs held low
   assign lnk.tclk          = r.clk;
   assign lnk.rclk          = r.clk;
   assign lnk.tser          = r.tser;
   assign lnk.rpos          = r.rline;
   assign lnk.rneg          = r.rline;
   assign lnk.tx_system_clock       = 1'b0;
   assign lnk.tx_system_sync        = 1'b0;
   assign lnk.rx_system_clock       = 1'b0;
   assign lnk.host_tsync_o  = 1'b0;
   assign lnk.host_tsync_oe = 1'b0;
   assign lnk.mux           = MUX_MODE;
   assign lnk.bts           = BTS_MODE;
   assign lnk.a             = {r.addr[7], r.addr[5:0]};
   assign lnk.ale_a6        = r.addr[6];
   assign lnk.fs            = r.fs;
   assign lnk.cs_n          = r.csn;
   assign lnk.rd_n          = r.rdn;
   assign lnk.wr_n          = r.wrn;
   assign lnk.host_d_o      = r.wdata;
   assign lnk.host_d_oe     = r.doe;
   assign lnk.test          = test_i;
   assign rdata_o           = r.rdata;
   assign busy_o            = (r.st != H_IDLE);
   assign done_o            = r.done;
   assign irq_o             = !r.stab[8];
endmodule

/* bench/e1_link_sva.sv */
module e1_link_sva (
   input wire logic       mclk_i,   // system clock
   input wire logic       nrst_i,   // async reset, active low
   input wire logic       tclk,     // transmit line clock
   input wire logic       tpos,     // positive rail out
   input wire logic       tneg,     // negative rail out
   input wire logic       rsync,    // resolved receive sync
   input wire logic       rx_multiframe_sync,   // receive multiframe sync
   input wire logic       tx_system_clock,  // tx system clock
   input wire logic       rx_system_clock,  // rx system clock
   input wire logic       tx_system_sync,   // tx system sync
   input wire logic       test,     // float control
   input wire logic       out_oe,   // plain outputs driven
   input wire logic       int_oe,   // interrupt pull-down
   input wire logic       dev_d_oe, // framer drives data bus
   input wire logic       rd_n,     // read strobe
   input wire logic       wr_n,     // write strobe
   input wire logic       cs_n,     // die select
   input wire logic [1:0] fs        // framer select
);
   logic       tclk_d_r;
   logic [3:0] tr_cnt_r;

   // cycles since tclk rose; rail updates must sit near the rising edge
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tclk_d_r <= 1'b0;
         tr_cnt_r <= 4'hF;
      end else begin
         tclk_d_r <= tclk;
         if (tclk && !tclk_d_r) tr_cnt_r <= 4'h0;
         else if (tr_cnt_r != 4'hF) tr_cnt_r <= tr_cnt_r + 4'h1;
      end
   end

   // sync pulses cut short by a float are not errors
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i || test);

   tclk_period_a: assert property ($rose(tclk) |-> tclk[*4] ##1 !tclk[*4]
      ##1 tclk) else $error("line clock period wrong");
   tx_edge_a: assert property ($changed({tpos, tneg}) |-> tr_cnt_r <= 4'h6)
      else $error("rails moved away from rising clock");
   rails_excl_a: assert property (!(tpos && tneg))
      else $error("both rails marked");
   rsync_width_a: assert property ($rose(rsync) |-> rsync[*8] ##1 !rsync)
      else $error("receive sync width wrong");
   rx_multiframe_sync_width_a: assert property ($rose(rx_multiframe_sync) |-> rx_multiframe_sync[*8]
      ##1 !rx_multiframe_sync) else $error("multiframe sync width wrong");
   sys_idle_a: assert property (!tx_system_clock && !rx_system_clock && !tx_system_sync)
      else $error("system clock or sync not held low");
   read_drive_a: assert property ($fell(rd_n) && !cs_n && fs == 2'h0
      |-> ##[2:8] dev_d_oe) else $error("selected read not driven");
   own_select_a: assert property (dev_d_oe |-> !cs_n && fs == 2'h0)
      else $error("data driven while not selected");
   strobe_excl_a: assert property (!rd_n |-> wr_n && !cs_n)
      else $error("strobes overlap or no select");
   test_float_a: assert property (disable iff (!nrst_i) test[*6]
      |-> !out_oe && !int_oe && !dev_d_oe)
      else $error("pins driven in float mode");

   cover property ($rose(rsync));
   cover property ($rose(rx_multiframe_sync));
   cover property (dev_d_oe);
   cover property (disable iff (!nrst_i) test && !out_oe);
endmodule

/* bench/test_e1_framer_pin_interface.sv */
module test_e1_framer_pin_interface;
   timeunit 1ns;
   timeprecision 1ns;
   import e1_pkg::*;

   logic       mclk_i = 1'b0, nrst_i = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [1:0] fs_s = 2'h0;
   logic       wr = 1'b0, rd = 1'b0, tx_bit = 1'b0, test_on = 1'b0;
   logic       busy, done, bipolar_violation, rx_mf, irq;
   int         err_count = 0, compares = 0, cyc = 0, bpv_cnt = 0;
   int         n, hp, hn;

   e1_link_if lnk();
   e1_framer_dev #(.FRAMER_ID(2'h0)) e1_framer_dev_i (.mclk_i(mclk_i),
      .nrst_i(nrst_i), .lnk(lnk), .bpv_o(bipolar_violation), .rx_mf_o(rx_mf));
   e1_host_end e1_host_end_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .lnk(lnk), .addr_i(addr), .fs_i(fs_s), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .busy_o(busy), .done_o(done),
      .tx_bit_i(tx_bit), .rx_line_i(1'b1), .test_i(test_on), .irq_o(irq));
   e1_link_sva e1_link_sva_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .tclk(lnk.tclk), .tpos(lnk.tpos), .tneg(lnk.tneg),
      .rsync(lnk.rsync), .rx_multiframe_sync(lnk.rx_multiframe_sync), .tx_system_clock(lnk.tx_system_clock),
      .rx_system_clock(lnk.rx_system_clock), .tx_system_sync(lnk.tx_system_sync), .test(lnk.test),
      .out_oe(lnk.out_oe), .int_oe(lnk.int_oe), .dev_d_oe(lnk.dev_d_oe),
      .rd_n(lnk.rd_n), .wr_n(lnk.wr_n), .cs_n(lnk.cs_n), .fs(lnk.fs));

   always #25 mclk_i = ~mclk_i;

   // hang guard: the multiframe wait dominates the run
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (bipolar_violation === 1'b1) bpv_cnt <= bpv_cnt + 1;
      if (cyc == 60000) begin
         err_count++;
         test_done();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one command on the host port, returns in the done cycle
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [1:0] f, input logic [7:0] d);
      int k;
      @(posedge mclk_i);
      wr <= w;
      rd <= !w;
      addr <= a;
      fs_s <= f;
      wdata <= d;
      @(posedge mclk_i);
      wr <= 1'b0;
      rd <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 40) begin
         @(posedge mclk_i);
         #1;
         k++;
      end
      if (k == 40) chk(8'h00, 8'h01);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [1:0] f,
                         input logic [7:0] exp);
      xfer(1'b0, a, f, 8'h00);
      chk(rdata, exp);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      // registers, the A6 pin as address bit and an unmapped place
      xfer(1'b1, REG_TCR1, 2'h0, 8'h80);
      rd_chk(REG_TCR1, 2'h0, 8'h80);
      xfer(1'b1, 8'h52, 2'h0, 8'h00);
      rd_chk(8'h52, 2'h0, 8'h00);
      rd_chk(REG_TCR1, 2'h0, 8'h80);
      xfer(1'b1, 8'h20, 2'h0, 8'h55);
      rd_chk(8'h20, 2'h0, 8'h00);
      // other framer indices do not reach this framer; their reads see the idle bus
      for (int f = 1; f < 4; f++) begin
         xfer(1'b1, REG_TCR1, f[1:0], 8'h00);
         rd_chk(REG_TCR1, f[1:0], 8'hFF);
      end
      rd_chk(REG_TCR1, 2'h0, 8'h80);
      $display("test registers done");
      // nrz on the positive rail, then alternate marks
      tx_bit <= 1'b1;
      repeat (80) @(posedge mclk_i);
      #1;
      chk({6'h0, lnk.tpos, lnk.tneg}, 8'h02);
      tx_bit <= 1'b0;
      repeat (80) @(posedge mclk_i);
      #1;
      chk({6'h0, lnk.tpos, lnk.tneg}, 8'h00);
      xfer(1'b1, REG_TCR1, 2'h0, 8'h00);
      tx_bit <= 1'b1;
      repeat (80) @(posedge mclk_i);
      hp = 0;
      hn = 0;
      repeat (40) begin
         @(posedge mclk_i);
         #1;
         if (lnk.tpos === 1'b1) hp++;
         if (lnk.tneg === 1'b1) hn++;
      end
      chk({6'h0, hp > 0, hn > 0}, 8'h03);
      $display("test transmit rails done");
      // interrupt raised by frame status, then masked
      xfer(1'b1, REG_SR1, 2'h0, 8'hFF);
      xfer(1'b1, REG_IMR1, 2'h0, 8'h02);
      n = 0;
      while (irq !== 1'b1 && n < 2600) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk({7'h0, lnk.int_n}, 8'h00);
      xfer(1'b1, REG_IMR1, 2'h0, 8'h00);
      repeat (6) @(posedge mclk_i);
      #1;
      chk({6'h0, irq, lnk.int_n}, 8'h01);
      $display("test interrupt done");
      // multiframe boundary on the receive side, tied rails never flag
      n = 0;
      while (rx_mf !== 1'b1 && n < 34000) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      // tx and rx counters share a start, so tx multiframe flags too
      rd_chk(REG_SR1, 2'h0, 8'h0E);
      chk(bpv_cnt[7:0], 8'h00);
      $display("test receive done");
      // transmit sync programmed as an output marks frame boundaries
      xfer(1'b1, REG_CCR1, 2'h0, 8'h08);
      rd_chk(REG_CCR1, 2'h0, 8'h08);
      n = 0;
      while (lnk.tsync !== 1'b1 && n < 2200) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk({7'h0, lnk.tsync}, 8'h01);
      xfer(1'b1, REG_CCR1, 2'h0, 8'h00);
      $display("test transmit sync done");
      // float mode releases every pin, reads see the idle bus
      test_on <= 1'b1;
      repeat (8) @(posedge mclk_i);
      #1;
      chk({7'h0, lnk.out_oe}, 8'h00);
      rd_chk(REG_TCR1, 2'h0, 8'hFF);
      test_on <= 1'b0;
      repeat (8) @(posedge mclk_i);
      rd_chk(REG_IMR1, 2'h0, 8'h00);
      $display("test float done");
      test_done();
   end
endmodule
